// ### rtl/rx_packet_filter_config.sv
`timescale 1ns/10ps
module rx_packet_filter_config
	import rx_filter_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input reg_req_s reg_req,
	output logic [7:0] reg_rdata,
	input rx_bit_s rx,
	input wire logic [7:0] sync_pattern_high,
	input wire logic [7:0] device_address,
	input wire logic length_variable,
	input wire logic checksum_enable,
	input wire logic [7:0] received_signal_strength,
	input wire logic [6:0] link_quality_value,
	input wire logic fifo_rd,
	output logic [7:0] fifo_rdata,
	output logic [6:0] fifo_level,
	output logic sync_found,
	output logic pkt_done,
	output logic pkt_crc_ok
);

	typedef struct packed {
		pkt_state_e st;
		logic [15:0] sync_sh;
		logic [2:0] bit_cnt;
		logic [7:0] byte_sh;
		logic [7:0] remaining;
		logic first_body;
		logic crc_half;
		logic [15:0] crc;
		logic [15:0] crc_rx;
		logic crc_ok;
		logic [6:0] wptr;
		logic [6:0] rptr;
		logic [6:0] pkt_start;
		logic [6:0] level;
		logic [7:0] sync_low;
		logic [7:0] pkt_len;
		logic [7:0] pkt_ctrl;
		logic [7:0] rdata;
		logic sync_found;
		logic pkt_done;
		logic pkt_ok;
	} top_state_s;

	top_state_s cur_ff;
	top_state_s nxt_cur;

	logic pq_reached;
	logic [2:0] preamble_quality_threshold;
	logic [1:0] addr_mode;
	logic flush_en;
	logic trailer_en;
	logic [7:0] new_byte;
	logic [15:0] new_sync;
	logic byte_done;
	logic wr_req;
	logic [7:0] wr_data;
	logic mem_we;
	logic rd_take;
	logic fifo_empty;
	logic fifo_full;
	logic sync_hit;
	logic quality_ok;
	logic len_bad;
	logic addr_ok;
	logic last_body;
	logic crc_match;
	logic bad_flush;

	////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [15:0] crc_step(input logic [15:0] crc,
		input logic b);
		logic fb;
		fb = crc[15] ^ b;
		crc_step = {crc[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
	endfunction

	function automatic logic addr_pass(input logic [1:0] mode,
		input logic [7:0] a, input logic [7:0] own);
		logic ok;
		ok = (a == own);
		case (mode)
			ADDR_MODE_OFF: ok = 1'b1;
			ADDR_MODE_OWN: ok = ok;
			ADDR_MODE_BC0: ok = ok || (a == BCAST_ZERO);
			ADDR_MODE_BC01: ok = ok || (a == BCAST_ZERO) || (a == BCAST_ONES);
			default: ok = 1'b1;
		endcase
		addr_pass = ok;
	endfunction

	function automatic logic [7:0] reg_value(input logic [5:0] a,
		input top_state_s s);
		case (a)
			SYNC_LOW_ADDR: reg_value = s.sync_low;
			PKT_LEN_ADDR: reg_value = s.pkt_len;
			PKT_CTRL_ADDR: reg_value = s.pkt_ctrl;
			default: reg_value = 8'h00;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////
	// field decode

	assign preamble_quality_threshold = cur_ff.pkt_ctrl[PQT_MSB:PQT_LSB];
	assign flush_en = cur_ff.pkt_ctrl[FLUSH_BIT];
	assign trailer_en = cur_ff.pkt_ctrl[TRAILER_BIT];
	assign addr_mode = cur_ff.pkt_ctrl[ADDR_MODE_MSB:ADDR_MODE_LSB];
	assign new_byte = {cur_ff.byte_sh[6:0], rx.bit_val};
	assign new_sync = {cur_ff.sync_sh[14:0], rx.bit_val};
	assign byte_done = rx.valid && (cur_ff.bit_cnt == 3'h7);
	assign rd_take = fifo_rd && !fifo_empty;

	assign reg_rdata = cur_ff.rdata;
	assign fifo_level = cur_ff.level;
	assign sync_found = cur_ff.sync_found;
	assign pkt_done = cur_ff.pkt_done;
	assign pkt_crc_ok = cur_ff.pkt_ok;

	////////////////////////////////////////////////////////////////
	// derived conditions

	assign fifo_empty = (cur_ff.level == 7'h00);
	assign fifo_full = (cur_ff.level == FIFO_DEPTH);
	assign sync_hit = (new_sync == {sync_pattern_high, cur_ff.sync_low});
	// zero threshold lets any matching sync through
	assign quality_ok = (preamble_quality_threshold == 3'h0) || pq_reached;
	assign len_bad = (new_byte == 8'h00) || (new_byte > cur_ff.pkt_len);
	assign addr_ok = addr_pass(addr_mode, new_byte, device_address);
	assign last_body = (cur_ff.remaining == 8'h01);
	assign crc_match = ({cur_ff.crc_rx[14:0], rx.bit_val} == cur_ff.crc);
	assign bad_flush = (cur_ff.st == ST_FINISH) && !cur_ff.crc_ok &&
		flush_en;

	preamble_quality u_pq (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.rx(rx),
		.restart(cur_ff.sync_found),
		.threshold(preamble_quality_threshold),
		.reached(pq_reached)
	);

	rx_fifo_mem u_mem (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.we(mem_we),
		.waddr(cur_ff.wptr[FIFO_AW-1:0]),
		.wdata(wr_data),
		.re(rd_take),
		.raddr(cur_ff.rptr[FIFO_AW-1:0]),
		.rdata(fifo_rdata)
	);

	////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.sync_found = 1'b0;
		nxt_cur.pkt_done = 1'b0;
		wr_req = 1'b0;
		wr_data = 8'h00;
		mem_we = 1'b0;

		if (reg_req.wr) begin
			case (reg_req.addr)
				SYNC_LOW_ADDR: nxt_cur.sync_low = reg_req.wdata;
				PKT_LEN_ADDR: nxt_cur.pkt_len = reg_req.wdata;
				PKT_CTRL_ADDR: nxt_cur.pkt_ctrl = reg_req.wdata & PKT_CTRL_WMASK;
				default: nxt_cur.pkt_ctrl = cur_ff.pkt_ctrl;
			endcase
		end
		nxt_cur.rdata = reg_value(reg_req.addr, cur_ff);

		if (rd_take) begin
			nxt_cur.rptr = cur_ff.rptr + 7'h01;
		end
		if (rx.valid) begin
			nxt_cur.byte_sh = new_byte;
			nxt_cur.bit_cnt = cur_ff.bit_cnt + 3'h1;
		end

		case (cur_ff.st)
			ST_HUNT: begin
				if (rx.valid) begin
					nxt_cur.sync_sh = new_sync;
					if (sync_hit && quality_ok &&
						(length_variable || (cur_ff.pkt_len != 8'h00))) begin
						nxt_cur.st = length_variable ? ST_LENGTH : ST_BODY;
						nxt_cur.remaining = cur_ff.pkt_len;
						nxt_cur.bit_cnt = 3'h0;
						nxt_cur.crc = CRC_INIT;
						nxt_cur.first_body = 1'b1;
						nxt_cur.crc_half = 1'b0;
						nxt_cur.pkt_start = cur_ff.wptr;
						nxt_cur.sync_sh = 16'h0000;
						nxt_cur.sync_found = 1'b1;
					end
				end
			end
			ST_LENGTH: begin
				if (rx.valid) begin
					nxt_cur.crc = crc_step(cur_ff.crc, rx.bit_val);
				end
				if (byte_done) begin
					if (len_bad) begin
						nxt_cur.st = ST_HUNT;
					end else begin
						nxt_cur.remaining = new_byte;
						wr_req = 1'b1;
						wr_data = new_byte;
						nxt_cur.st = ST_BODY;
					end
				end
			end
			ST_BODY: begin
				if (rx.valid) begin
					nxt_cur.crc = crc_step(cur_ff.crc, rx.bit_val);
				end
				if (byte_done) begin
					nxt_cur.first_body = 1'b0;
					if (cur_ff.first_body && !addr_ok) begin
						nxt_cur.wptr = cur_ff.pkt_start;
						nxt_cur.st = ST_HUNT;
					end else begin
						wr_req = 1'b1;
						wr_data = new_byte;
						nxt_cur.remaining = cur_ff.remaining - 8'h01;
						if (last_body) begin
							nxt_cur.crc_ok = 1'b1;
							if (checksum_enable) begin
								nxt_cur.st = ST_CHECK;
							end else if (trailer_en) begin
								nxt_cur.st = ST_TRAIL_RECEIVED_SIGNAL_STRENGTH;
							end else begin
								nxt_cur.st = ST_FINISH;
							end
						end
					end
				end
			end
			ST_CHECK: begin
				if (rx.valid) begin
					nxt_cur.crc_rx = {cur_ff.crc_rx[14:0], rx.bit_val};
				end
				if (byte_done) begin
					nxt_cur.crc_half = 1'b1;
					if (cur_ff.crc_half) begin
						nxt_cur.crc_ok = crc_match;
						nxt_cur.st = trailer_en ? ST_TRAIL_RECEIVED_SIGNAL_STRENGTH : ST_FINISH;
					end
				end
			end
			ST_TRAIL_RECEIVED_SIGNAL_STRENGTH: begin
				wr_req = 1'b1;
				wr_data = received_signal_strength;
				nxt_cur.st = ST_TRAIL_LQI;
			end
			ST_TRAIL_LQI: begin
				wr_req = 1'b1;
				wr_data = {cur_ff.crc_ok, link_quality_value};
				nxt_cur.st = ST_FINISH;
			end
			ST_FINISH: begin
				nxt_cur.pkt_done = 1'b1;
				nxt_cur.pkt_ok = cur_ff.crc_ok;
				nxt_cur.st = ST_HUNT;
			end
			default: nxt_cur.st = ST_HUNT;
		endcase

		// bytes arriving with no room are dropped
		if (wr_req && !fifo_full) begin
			mem_we = 1'b1;
			nxt_cur.wptr = cur_ff.wptr + 7'h01;
		end

		// relies on a single packet held in the FIFO
		if (bad_flush) begin
			nxt_cur.wptr = 7'h00;
			nxt_cur.rptr = 7'h00;
		end
		nxt_cur.level = nxt_cur.wptr - nxt_cur.rptr;
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cur_ff <= '0;
			cur_ff.st <= ST_HUNT;
			cur_ff.sync_low <= SYNC_LOW_RESET;
			cur_ff.pkt_len <= PKT_LEN_RESET;
			cur_ff.pkt_ctrl <= PKT_CTRL_RESET;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

endmodule

// ### pkg/rx_filter_pkg.sv
// Contract
// - sync_pattern_low is the low byte of the 16-bit sync pattern.
// - fixed framing: packet_length_limit is the exact payload length.
// - variable framing: packet_length_limit is the largest length accepted.
// - quality counter gains one per bit change, loses eight per repeat.
// - sync detection allowed only while counter reaches four times threshold.
// - threshold zero accepts any matching sync pattern.
// - bad_checksum_flush set: failed checksum empties the receive FIFO.
// - status_trailer_enable set: two status bytes follow the payload.
// - status bytes hold signal strength, link quality, checksum-passed flag.
// - filter modes: none, own, plus 0x00, plus 0x00 and 0xFF.
// - sync_pattern_high is the high byte of the sync pattern.
// - variable framing takes length from first byte after sync.
// - address byte is compared with own-address value.
package rx_filter_pkg;

	localparam logic [5:0] SYNC_LOW_ADDR = 6'h05;
	localparam logic [5:0] PKT_LEN_ADDR = 6'h06;
	localparam logic [5:0] PKT_CTRL_ADDR = 6'h07;

	localparam logic [7:0] SYNC_LOW_RESET = 8'h91;
	localparam logic [7:0] PKT_LEN_RESET = 8'hFF;
	localparam logic [7:0] PKT_CTRL_RESET = 8'h04;
	localparam logic [7:0] PKT_CTRL_WMASK = 8'hEF;

	localparam int PQT_MSB = 7;
	localparam int PQT_LSB = 5;
	localparam int FLUSH_BIT = 3;
	localparam int TRAILER_BIT = 2;
	localparam int ADDR_MODE_MSB = 1;
	localparam int ADDR_MODE_LSB = 0;

	localparam logic [1:0] ADDR_MODE_OFF = 2'h0;
	localparam logic [1:0] ADDR_MODE_OWN = 2'h1;
	localparam logic [1:0] ADDR_MODE_BC0 = 2'h2;
	localparam logic [1:0] ADDR_MODE_BC01 = 2'h3;
	localparam logic [7:0] BCAST_ZERO = 8'h00;
	localparam logic [7:0] BCAST_ONES = 8'hFF;

	localparam int PQ_CNT_W = 8;
	localparam logic [7:0] PQ_STEP_UP = 8'h01;
	localparam logic [7:0] PQ_STEP_DOWN = 8'h08;
	localparam logic [7:0] PQ_CNT_MAX = 8'hFF;
	localparam int PQ_SCALE_SHIFT = 2;

	localparam logic [15:0] CRC_POLY = 16'h8005;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;

	localparam int FIFO_AW = 6;
	localparam logic [6:0] FIFO_DEPTH = 7'h40;

	typedef struct packed {
		logic [5:0] addr;
		logic [7:0] wdata;
		logic wr;
	} reg_req_s;

	typedef struct packed {
		logic bit_val;
		logic valid;
	} rx_bit_s;

	typedef enum logic [6:0] {
		ST_HUNT = 7'b0000001,
		ST_LENGTH = 7'b0000010,
		ST_BODY = 7'b0000100,
		ST_CHECK = 7'b0001000,
		ST_TRAIL_RECEIVED_SIGNAL_STRENGTH = 7'b0010000,
		ST_TRAIL_LQI = 7'b0100000,
		ST_FINISH = 7'b1000000
	} pkt_state_e;

endpackage

// ### rtl/preamble_quality.sv
`timescale 1ns/10ps
module preamble_quality
	import rx_filter_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input rx_bit_s rx,
	input wire logic restart,
	input wire logic [2:0] threshold,
	output logic reached
);

	typedef struct packed {
		logic [7:0] cnt;
		logic last;
		logic have_last;
		logic reached;
	} pq_state_s;

	pq_state_s cur_ff;
	pq_state_s nxt_cur;
	logic [7:0] limit;

	assign limit = {3'h0, threshold, 2'h0};
	assign reached = cur_ff.reached;

	always_comb begin
		nxt_cur = cur_ff;
		if (restart) begin
			nxt_cur.cnt = 8'h00;
			nxt_cur.have_last = 1'b0;
		end else if (rx.valid) begin
			nxt_cur.last = rx.bit_val;
			nxt_cur.have_last = 1'b1;
			if (cur_ff.have_last && (rx.bit_val != cur_ff.last)) begin
				if (cur_ff.cnt != PQ_CNT_MAX) begin
					nxt_cur.cnt = cur_ff.cnt + PQ_STEP_UP;
				end
			end else if (cur_ff.have_last) begin
				if (cur_ff.cnt > PQ_STEP_DOWN) begin
					nxt_cur.cnt = cur_ff.cnt - PQ_STEP_DOWN;
				end else begin
					nxt_cur.cnt = 8'h00;
				end
			end
		end
		nxt_cur.reached = (nxt_cur.cnt >= limit);
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

endmodule

// ### rtl/rx_fifo_mem.sv
`timescale 1ns/10ps
module rx_fifo_mem
	import rx_filter_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic we,
	input wire logic [5:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic re,
	input wire logic [5:0] raddr,
	output logic [7:0] rdata
);

	typedef struct packed {
		logic [63:0][7:0] mem;
		logic [7:0] rdata;
	} mem_state_s;

	mem_state_s cur_ff;
	mem_state_s nxt_cur;

	assign rdata = cur_ff.rdata;

	always_comb begin
		nxt_cur = cur_ff;
		if (we) begin
			nxt_cur.mem[waddr] = wdata;
		end
		if (re) begin
			nxt_cur.rdata = cur_ff.mem[raddr];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

endmodule

// ### verif/rx_filter_properties.sv
`timescale 1ns/10ps
module rx_filter_properties
	import rx_filter_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input reg_req_s reg_req,
	input logic [7:0] reg_rdata,
	input rx_bit_s rx,
	input wire logic checksum_enable,
	input logic [6:0] fifo_level,
	input logic sync_found,
	input logic pkt_done,
	input logic pkt_crc_ok
);
default clocking @(posedge clk_sys); endclocking
default disable iff (!rst_b);
logic [7:0] low_ff, len_ff, ctl_ff;
// shadow copies of the three registers
always_ff @(posedge clk_sys or negedge rst_b) begin
	if (!rst_b) begin
		low_ff <= SYNC_LOW_RESET;
		len_ff <= PKT_LEN_RESET;
		ctl_ff <= PKT_CTRL_RESET;
	end else if (reg_req.wr) begin
		if (reg_req.addr == SYNC_LOW_ADDR) low_ff <= reg_req.wdata;
		if (reg_req.addr == PKT_LEN_ADDR) len_ff <= reg_req.wdata;
		if (reg_req.addr == PKT_CTRL_ADDR)
			ctl_ff <= reg_req.wdata & PKT_CTRL_WMASK;
	end
end
sequence s_rd(logic [5:0] a);
	$past(rst_b) && $past(reg_req.addr) == a;
endsequence
sequence s_done_ok;
	pkt_done && pkt_crc_ok;
endsequence
////////////////////////////////////////
a_low_read: assert property (
	s_rd(SYNC_LOW_ADDR) |-> reg_rdata == $past(low_ff))
	else $error("sync low readback wrong");
a_len_read: assert property (
	s_rd(PKT_LEN_ADDR) |-> reg_rdata == $past(len_ff))
	else $error("length readback wrong");
a_ctrl_read: assert property (
	s_rd(PKT_CTRL_ADDR) |-> reg_rdata == $past(ctl_ff))
	else $error("control readback wrong");
a_sync_cause: assert property (
	sync_found |-> $past(rx.valid))
	else $error("sync pulse without a bit");
a_done_pulse: assert property (
	pkt_done |=> !pkt_done)
	else $error("done pulse too long");
a_flush_empty: assert property (
	pkt_done && !pkt_crc_ok && ctl_ff[FLUSH_BIT] |-> fifo_level == 7'h00)
	else $error("fifo not flushed");
a_trailer_kept: assert property (
	s_done_ok ##0 ctl_ff[TRAILER_BIT] |-> fifo_level >= 7'h02)
	else $error("status bytes missing");
a_crc_off: assert property (
	pkt_done && !checksum_enable |-> pkt_crc_ok)
	else $error("checksum flag low with check off");
endmodule
bind rx_packet_filter_config rx_filter_properties rx_filter_properties_inst (
	.clk_sys, .rst_b, .reg_req, .reg_rdata, .rx, .checksum_enable,
	.fifo_level, .sync_found, .pkt_done, .pkt_crc_ok
);

// ### verif/radio_bit_source.sv
`timescale 1ns/10ps
module radio_bit_source
	import rx_filter_pkg::*;
(
	input wire logic clk_sys,
	output rx_bit_s rx
);
initial rx = '0;
// line shows the inverse bit once the strobe drops
task automatic put_bit(input logic b, input int gap);
	@(negedge clk_sys);
	rx = {b, 1'b1};
	@(negedge clk_sys);
	rx = {~b, 1'b0};
	repeat (gap) @(negedge clk_sys);
endtask
endmodule

// ### verif/test_rx_packet_filter_config.sv
`timescale 1ns/10ps
module test_rx_packet_filter_config
	import rx_filter_pkg::*;
;
logic clk_sys = 0;
logic rst_b = 0;
reg_req_s reg_req = '0;
rx_bit_s rx;
logic [7:0] reg_rdata, fifo_rdata, device_address, plen = 8'hFF, ctl;
logic [7:0] sync_high = 8'hAA;
logic [7:0] received_signal_strength;
logic [6:0] fifo_level, link_quality_value;
logic sync_found, pkt_done, pkt_crc_ok, fifo_rd = 0;
logic length_variable = 0, checksum_enable = 0, last, seeded;
logic [15:0] sr;
int err_total, compares, seed = 4042, n_sync, n_done, x_sync, pq, hunt;
always #12.5 clk_sys = ~clk_sys;
rx_packet_filter_config rx_packet_filter_config_inst (
	.clk_sys, .rst_b, .reg_req, .reg_rdata, .rx, .sync_pattern_high(sync_high),
	.device_address, .length_variable, .checksum_enable,
	.received_signal_strength, .link_quality_value, .fifo_rd,
	.fifo_rdata, .fifo_level, .sync_found, .pkt_done, .pkt_crc_ok
);
radio_bit_source radio_bit_source_inst (.clk_sys, .rx);
always @(negedge clk_sys) begin
	n_sync += (sync_found === 1'b1);
	n_done += (pkt_done === 1'b1);
end
////////////////////////////////////////
task automatic check(input string w, input logic [31:0] s, e);
	compares++;
	if (s !== e) begin
		err_total++;
		$display("unexpected %s exp %0h seen %0h", w, e, s);
	end
endtask
task automatic finish_test;
	$display("errors %0d compares %0d", err_total, compares);
	if (err_total == 0 && compares > 0) begin
		$display("Simulation passed");
	end else begin
		$display("Simulation failed");
	end
	$finish;
endtask
task automatic wr(input logic [5:0] a, input logic [7:0] d);
	@(negedge clk_sys);
	reg_req = {a, d, 1'b1};
	@(negedge clk_sys);
	reg_req.wr = 0;
endtask
task automatic rd(input logic [5:0] a, input logic [7:0] e);
	@(negedge clk_sys);
	reg_req.addr = a;
	@(negedge clk_sys);
	check("reg", reg_rdata, e);
endtask
task automatic set_ctl(input logic [7:0] v);
	ctl = v;
	wr(PKT_CTRL_ADDR, v);
endtask
task automatic pulse_rd;
	@(negedge clk_sys);
	fifo_rd = 1;
	@(negedge clk_sys);
	fifo_rd = 0;
endtask
function automatic logic [15:0] crc16(input logic [7:0] q[$]);
	logic [15:0] c;
	c = CRC_INIT;
	foreach (q[j]) begin
		for (int i = 7; i >= 0; i--) begin
			c = {c[14:0], 1'b0} ^ (c[15] ^ q[j][i] ? CRC_POLY : 16'h0000);
		end
	end
	return c;
endfunction
// hunt model: quality counter and sync search
task automatic send(input logic [7:0] v);
	logic g;
	for (int i = 7; i >= 0; i--) begin
		if (hunt) begin
			sr = {sr[14:0], v[i]};
			// gate reflects the counter before this bit
			g = pq >= 4 * ctl[7:5];
			if (seeded) pq = v[i] != last ? pq + 1 : pq - 8;
			pq = pq > 255 ? 255 : pq < 0 ? 0 : pq;
			seeded = 1;
			last = v[i];
			if (sr == {sync_high, 8'hB5} && g) begin
				hunt = 0;
				x_sync++;
				pq = 0;
				seeded = 0;
			end
		end
		radio_bit_source_inst.put_bit(v[i], $random(seed) & 1);
	end
endtask
task automatic frame(input int pre, input logic [7:0] len, adr, bad);
	logic [7:0] k[$];
	logic [15:0] c;
	int x0, d0, n;
	logic ok, drop, hit;
	received_signal_strength = $random(seed);
	link_quality_value = $random(seed);
	x0 = x_sync;
	d0 = n_done;
	hunt = 1;
	send(8'h00);
	send(8'h00);
	repeat (pre) send(8'hAA);
	send(sync_high);
	send(8'hB5);
	n = length_variable ? len : plen;
	if (length_variable) k.push_back(len);
	k.push_back(adr);
	repeat (n - 1) k.push_back($random(seed));
	c = crc16(k) ^ {15'h0, bad[0]};
	if (x_sync != x0) begin
		foreach (k[j]) send(k[j]);
		if (checksum_enable) send(c[15:8]);
		if (checksum_enable) send(c[7:0]);
	end
	ok = !checksum_enable || !bad[0];
	drop = x_sync == x0 || length_variable && (len == 0 || len > plen);
	hit = adr == device_address || ctl[1] && adr == 8'h00;
	if (ctl[1:0] == 2'h3 && adr == 8'hFF) hit = 1;
	if (ctl[1:0] != 2'h0 && !hit) drop = 1;
	if (drop) begin
		repeat (40) @(negedge clk_sys);
		k.delete();
	end else begin
		for (int i = 0; i < 400 && n_done == d0; i++) @(negedge clk_sys);
		check("done", n_done - d0, 1);
		check("crc_ok", pkt_crc_ok, ok);
		if (ctl[2]) k.push_back(received_signal_strength);
		if (ctl[2]) k.push_back({ok, link_quality_value});
		if (ctl[3] && !ok) k.delete();
	end
	check("sync", n_sync, x_sync);
	check("level", fifo_level, k.size());
	while (k.size() > 0) begin
		pulse_rd();
		check("fifo", fifo_rdata, k.pop_front());
	end
	pulse_rd();
	check("empty", fifo_level, 0);
endtask
////////////////////////////////////////
initial begin
	device_address = $random(seed) & 8'h3E | 8'h41;
	repeat (20) @(negedge clk_sys);
	rst_b = 1;
	rd(SYNC_LOW_ADDR, SYNC_LOW_RESET);
	rd(PKT_LEN_ADDR, PKT_LEN_RESET);
	rd(PKT_CTRL_ADDR, PKT_CTRL_RESET);
	rd(6'h08, 8'h00);
	wr(PKT_CTRL_ADDR, 8'hFF);
	rd(PKT_CTRL_ADDR, 8'hEF);
	wr(SYNC_LOW_ADDR, 8'hB5);
	rd(SYNC_LOW_ADDR, 8'hB5);
	plen = 8'h05;
	wr(PKT_LEN_ADDR, plen);
	rd(PKT_LEN_ADDR, plen);
	set_ctl(8'h04);
	frame(0, 0, 8'h33, 0);
	checksum_enable = 1;
	frame(0, 0, 8'h33, 0);
	frame(0, 0, 8'h33, 1);
	set_ctl(8'h0C);
	frame(0, 0, 8'h33, 1);
	frame(0, 0, 8'h33, 0);
	set_ctl(8'h00);
	frame(0, 0, 8'h33, 0);
	for (int m = 1; m < 4; m++) begin
		set_ctl(8'h04 | 8'(m));
		frame(0, 0, device_address, 0);
		frame(0, 0, 8'h00, 0);
		frame(0, 0, 8'hFF, 0);
		frame(0, 0, device_address ^ 8'h20, 0);
	end
	set_ctl(8'h04);
	length_variable = 1;
	frame(0, 8'h03, 8'h33, 0);
	frame(0, 8'h00, 8'h33, 0);
	frame(0, 8'h05, 8'h33, 0);
	frame(0, 8'h06, 8'h33, 0);
	set_ctl(8'h44);
	frame(0, 8'h03, 8'h33, 0);
	set_ctl(8'h24);
	frame(0, 8'h03, 8'h33, 0);
	set_ctl(8'hE4);
	frame(4, 8'h03, 8'h33, 0);
	frame(0, 8'h03, 8'h33, 0);
	set_ctl(8'h04);
	sync_high = 8'h3C;
	frame(0, 8'h03, 8'h33, 0);
	finish_test();
end
initial begin
	#1500000;
	err_total++;
	finish_test();
end
endmodule
